// ==== verilog/i2c_flags_pkg.sv ====
// constants shared by the two-wire bus status flag logic
package i2c_flags_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int CODE_W = 3;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_MODE_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_VECTOR = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_RX_DATA = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TX_DATA = 8'h14;

   // ----------------------------------------------------------------
   // field positions, status and mask share one layout
   // ----------------------------------------------------------------
   localparam int BIT_GENERAL_CALL = 8;
   localparam int BIT_STOP_SEEN = 5;
   localparam int BIT_TX_READY = 4;
   localparam int BIT_RX_READY = 3;
   localparam int BIT_REGS_READY = 2;
   localparam int BIT_MODULE_RESET_RELEASE = 0;
   localparam logic [DATA_W-1:0] FLAG_BITS = 16'h013c;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] MODE_CONTROL_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] IRQ_MASK_RESET = 16'h0000;
   localparam logic [BYTE_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

   // ----------------------------------------------------------------
   // bus address and vector codes
   // ----------------------------------------------------------------
   localparam logic [BYTE_W-1:0] GENERAL_CALL_ADDR = 8'h00;
   localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
   localparam logic [CODE_W-1:0] CODE_REGS_READY = 3'h1;
   localparam logic [CODE_W-1:0] CODE_RX_READY = 3'h4;
   localparam logic [CODE_W-1:0] CODE_TX_READY = 3'h5;
   localparam logic [CODE_W-1:0] CODE_STOP_SEEN = 3'h6;
   localparam logic [CODE_W-1:0] CODE_GENERAL_CALL = 3'h7;

endpackage

// ==== verilog/sticky_flag.sv ====
// one status flag: forced while held, set wins over clear
`timescale 1ns/10ps
module sticky_flag #(
   parameter logic RESET_VAL = 1'b0,
   parameter logic HOLD_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hold,
   input wire logic set,
   input wire logic clr,
   output logic flag
);

   logic flag_d;
   logic flag_q;

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   always_comb begin
      flag_d = flag_q;
      if (hold) begin
         flag_d = HOLD_VAL;
      end else if (set) begin
         // an event in the clearing cycle must not be lost
         flag_d = 1'b1;
      end else if (clr) begin
         flag_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag = flag_q;

endmodule

// ==== verilog/data_byte_reg.sv ====
// one byte holding register with load enable
`timescale 1ns/10ps
module data_byte_reg (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [i2c_flags_pkg::BYTE_W-1:0] din,
   output logic [i2c_flags_pkg::BYTE_W-1:0] dout
);

   logic [i2c_flags_pkg::BYTE_W-1:0] data_d;
   logic [i2c_flags_pkg::BYTE_W-1:0] data_q;

   // ----------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------
   always_comb begin
      data_d = data_q;
      if (load) begin
         data_d = din;
      end
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         data_q <= i2c_flags_pkg::DATA_RESET;
      end else begin
         data_q <= data_d;
      end
   end

   assign dout = data_q;

endmodule

// ==== verilog/i2c_status_flags.sv ====
// status flags, masks and interrupt requests of a two-wire bus controller
//
// Operation
// - Set the general-call flag when the received bus address is all zeros.
// - Clear the general-call flag on every start or stop condition.
// - Reserved status bits 7-6 read as zero and ignore writes.
// - Set the stop-seen flag on any stop condition, whoever drove it.
// - Clear the stop-seen flag when a vector read returns the stop code 110b.
// - Writing one to the stop-seen flag clears it, writing zero keeps it.
// - Set the transmit-ready flag when transmit data moves to the shift register.
// - Clear the transmit-ready flag on a transmit data write or a write of one.
// - Hold the transmit-ready flag at one while the module is in reset.
// - Offer transmit-ready and receive-ready both as status and as requests.
// - Set the receive-ready flag when a byte moves into the receive data register.
// - Clear the receive-ready flag on a receive data read or a write of one.
// - Clear the receive-ready flag on module reset or processor reset.
// - In master mode set the access-ready flag once programmed values are used.
// - Clear the access-ready flag when the engine starts on the current values.
// - Writing one to the access-ready flag clears it.
`timescale 1ns/10ps
module i2c_status_flags (
   input wire logic clk,
   input wire logic arst_n,
   // register port
   input wire logic [i2c_flags_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [i2c_flags_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [i2c_flags_pkg::DATA_W-1:0] reg_rdata,
   // events from the bus engine
   input wire logic master_mode,
   input wire logic start_seen,
   input wire logic stop_seen,
   input wire logic addr_valid,
   input wire logic [i2c_flags_pkg::BYTE_W-1:0] addr_byte,
   input wire logic tx_copied,
   input wire logic rx_copied,
   input wire logic [i2c_flags_pkg::BYTE_W-1:0] rx_shift_reg,
   input wire logic regs_consumed,
   input wire logic regs_start,
   // towards the engine and the processor
   output logic [i2c_flags_pkg::BYTE_W-1:0] tx_data,
   output logic module_in_reset,
   output logic tx_ready_request,
   output logic rx_ready_request,
   output logic regs_ready_request,
   output logic irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [i2c_flags_pkg::DATA_W-1:0] mode_control_d;
   logic [i2c_flags_pkg::DATA_W-1:0] mode_control_q;
   logic [i2c_flags_pkg::DATA_W-1:0] irq_mask_d;
   logic [i2c_flags_pkg::DATA_W-1:0] irq_mask_q;
   logic [i2c_flags_pkg::DATA_W-1:0] rdata_d;
   logic [i2c_flags_pkg::DATA_W-1:0] rdata_q;
   logic [i2c_flags_pkg::DATA_W-1:0] status;
   logic [i2c_flags_pkg::DATA_W-1:0] pending;
   logic [i2c_flags_pkg::CODE_W-1:0] vector_code;
   logic [i2c_flags_pkg::BYTE_W-1:0] tx_data_q;
   logic [i2c_flags_pkg::BYTE_W-1:0] rx_data_q;
   logic tx_req_d;
   logic tx_req_q;
   logic rx_req_d;
   logic rx_req_q;
   logic regs_req_d;
   logic regs_req_q;
   logic irq_d;
   logic irq_q;
   logic in_reset_q;
   logic held;
   logic wr_mode;
   logic wr_mask;
   logic wr_status;
   logic wr_tx_data;
   logic rd_vector;
   logic rd_rx_data;
   logic gc_flag;
   logic stop_flag;
   logic tx_flag;
   logic rx_flag;
   logic regs_flag;
   logic gc_set;
   logic gc_clr;
   logic stop_set;
   logic stop_clr;
   logic tx_set;
   logic tx_clr;
   logic rx_set;
   logic rx_clr;
   logic regs_set;
   logic regs_clr;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   always_comb begin
      wr_mode = 1'b0;
      wr_mask = 1'b0;
      wr_status = 1'b0;
      wr_tx_data = 1'b0;
      if (reg_wr && reg_addr == i2c_flags_pkg::OFF_MODE_CONTROL) begin
         wr_mode = 1'b1;
      end else if (reg_wr && reg_addr == i2c_flags_pkg::OFF_IRQ_MASK) begin
         wr_mask = 1'b1;
      end else if (reg_wr && reg_addr == i2c_flags_pkg::OFF_STATUS) begin
         wr_status = 1'b1;
      end else if (reg_wr && reg_addr == i2c_flags_pkg::OFF_TX_DATA) begin
         wr_tx_data = 1'b1;
      end
   end

   always_comb begin
      rd_vector = 1'b0;
      rd_rx_data = 1'b0;
      if (reg_rd && reg_addr == i2c_flags_pkg::OFF_IRQ_VECTOR) begin
         rd_vector = 1'b1;
      end else if (reg_rd && reg_addr == i2c_flags_pkg::OFF_RX_DATA) begin
         rd_rx_data = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_comb begin
      mode_control_d = mode_control_q;
      irq_mask_d = irq_mask_q;
      if (wr_mode) begin
         mode_control_d = reg_wdata & 16'h0001;
      end
      if (wr_mask) begin
         // only flag positions hold a mask bit
         irq_mask_d = reg_wdata & i2c_flags_pkg::FLAG_BITS;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_control_q <= i2c_flags_pkg::MODE_CONTROL_RESET;
         irq_mask_q <= i2c_flags_pkg::IRQ_MASK_RESET;
      end else begin
         mode_control_q <= mode_control_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // module held in reset while the release bit reads zero
   assign held = ~mode_control_q[i2c_flags_pkg::BIT_MODULE_RESET_RELEASE];

   // ----------------------------------------------------------------
   // flag causes
   // ----------------------------------------------------------------
   always_comb begin
      gc_set = addr_valid && addr_byte == i2c_flags_pkg::GENERAL_CALL_ADDR;
      gc_clr = start_seen || stop_seen;
      stop_set = stop_seen;
      stop_clr = (wr_status && reg_wdata[i2c_flags_pkg::BIT_STOP_SEEN])
         || (rd_vector && vector_code == i2c_flags_pkg::CODE_STOP_SEEN);
      tx_set = tx_copied;
      tx_clr = wr_tx_data || (wr_status && reg_wdata[i2c_flags_pkg::BIT_TX_READY]);
      rx_set = rx_copied;
      rx_clr = rd_rx_data || (wr_status && reg_wdata[i2c_flags_pkg::BIT_RX_READY]);
      regs_set = master_mode && regs_consumed;
      regs_clr = regs_start
         || (wr_status && reg_wdata[i2c_flags_pkg::BIT_REGS_READY]);
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   sticky_flag #(.RESET_VAL(1'b0), .HOLD_VAL(1'b0)) u_gc_flag (
      .clk(clk),
      .arst_n(arst_n),
      .hold(held),
      .set(gc_set),
      .clr(gc_clr),
      .flag(gc_flag)
   );

   sticky_flag #(.RESET_VAL(1'b0), .HOLD_VAL(1'b0)) u_stop_flag (
      .clk(clk),
      .arst_n(arst_n),
      .hold(held),
      .set(stop_set),
      .clr(stop_clr),
      .flag(stop_flag)
   );

   // forced high in either reset
   sticky_flag #(.RESET_VAL(1'b1), .HOLD_VAL(1'b1)) u_tx_flag (
      .clk(clk),
      .arst_n(arst_n),
      .hold(held),
      .set(tx_set),
      .clr(tx_clr),
      .flag(tx_flag)
   );

   // cleared in either reset
   sticky_flag #(.RESET_VAL(1'b0), .HOLD_VAL(1'b0)) u_rx_flag (
      .clk(clk),
      .arst_n(arst_n),
      .hold(held),
      .set(rx_set),
      .clr(rx_clr),
      .flag(rx_flag)
   );

   sticky_flag #(.RESET_VAL(1'b0), .HOLD_VAL(1'b0)) u_regs_flag (
      .clk(clk),
      .arst_n(arst_n),
      .hold(held),
      .set(regs_set),
      .clr(regs_clr),
      .flag(regs_flag)
   );

   // ----------------------------------------------------------------
   // data registers
   // ----------------------------------------------------------------
   data_byte_reg u_tx_data_reg (
      .clk(clk),
      .arst_n(arst_n),
      .load(wr_tx_data),
      .din(reg_wdata[i2c_flags_pkg::BYTE_W-1:0]),
      .dout(tx_data_q)
   );

   data_byte_reg u_rx_data_reg (
      .clk(clk),
      .arst_n(arst_n),
      .load(rx_copied),
      .din(rx_shift_reg),
      .dout(rx_data_q)
   );

   // ----------------------------------------------------------------
   // status word and vector
   // ----------------------------------------------------------------
   always_comb begin
      // reserved positions stay zero
      status = 16'h0000;
      status[i2c_flags_pkg::BIT_GENERAL_CALL] = gc_flag;
      status[i2c_flags_pkg::BIT_STOP_SEEN] = stop_flag;
      status[i2c_flags_pkg::BIT_TX_READY] = tx_flag;
      status[i2c_flags_pkg::BIT_RX_READY] = rx_flag;
      status[i2c_flags_pkg::BIT_REGS_READY] = regs_flag;
      pending = status & irq_mask_q;
   end

   // fixed priority; masked flags never show in the vector
   always_comb begin
      vector_code = i2c_flags_pkg::CODE_NONE;
      if (pending[i2c_flags_pkg::BIT_REGS_READY]) begin
         vector_code = i2c_flags_pkg::CODE_REGS_READY;
      end else if (pending[i2c_flags_pkg::BIT_RX_READY]) begin
         vector_code = i2c_flags_pkg::CODE_RX_READY;
      end else if (pending[i2c_flags_pkg::BIT_TX_READY]) begin
         vector_code = i2c_flags_pkg::CODE_TX_READY;
      end else if (pending[i2c_flags_pkg::BIT_STOP_SEEN]) begin
         vector_code = i2c_flags_pkg::CODE_STOP_SEEN;
      end else if (pending[i2c_flags_pkg::BIT_GENERAL_CALL]) begin
         vector_code = i2c_flags_pkg::CODE_GENERAL_CALL;
      end
   end

   // ----------------------------------------------------------------
   // read data, valid the cycle after the strobe only
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = i2c_flags_pkg::READ_IDLE;
      if (reg_rd && reg_addr == i2c_flags_pkg::OFF_MODE_CONTROL) begin
         rdata_d = mode_control_q;
      end else if (reg_rd && reg_addr == i2c_flags_pkg::OFF_IRQ_MASK) begin
         rdata_d = irq_mask_q;
      end else if (reg_rd && reg_addr == i2c_flags_pkg::OFF_STATUS) begin
         rdata_d = status;
      end else if (rd_vector) begin
         rdata_d = {13'h0, vector_code};
      end else if (rd_rx_data) begin
         rdata_d = {8'h00, rx_data_q};
      end else if (reg_rd && reg_addr == i2c_flags_pkg::OFF_TX_DATA) begin
         rdata_d = {8'h00, tx_data_q};
      end
   end

   // ----------------------------------------------------------------
   // requests, one cycle behind the flags
   // ----------------------------------------------------------------
   always_comb begin
      tx_req_d = pending[i2c_flags_pkg::BIT_TX_READY];
      rx_req_d = pending[i2c_flags_pkg::BIT_RX_READY];
      regs_req_d = pending[i2c_flags_pkg::BIT_REGS_READY];
      irq_d = |pending;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= i2c_flags_pkg::READ_IDLE;
         tx_req_q <= 1'b0;
         rx_req_q <= 1'b0;
         regs_req_q <= 1'b0;
         irq_q <= 1'b0;
         in_reset_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         tx_req_q <= tx_req_d;
         rx_req_q <= rx_req_d;
         regs_req_q <= regs_req_d;
         irq_q <= irq_d;
         in_reset_q <= ~mode_control_d[i2c_flags_pkg::BIT_MODULE_RESET_RELEASE];
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata = rdata_q;
   assign tx_data = tx_data_q;
   assign module_in_reset = in_reset_q;
   assign tx_ready_request = tx_req_q;
   assign rx_ready_request = rx_req_q;
   assign regs_ready_request = regs_req_q;
   assign irq = irq_q;

endmodule

// ==== testbench/i2c_flags_chk.sv ====
// port-level assertions for the status flag block
`timescale 1ns/10ps
module i2c_flags_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic tx_copied,
   input wire logic rx_copied,
   input wire logic regs_consumed,
   input wire logic regs_start,
   input wire logic module_in_reset,
   input wire logic tx_ready_request,
   input wire logic rx_ready_request,
   input wire logic regs_ready_request
);
   // ----------------------------------------
   // mask mirror, requests depend on it
   // ----------------------------------------
   logic [15:0] mask_q;
   logic [15:0] mask_d;
   logic mask_wr;
   logic mode_wr;
   logic st_wr;
   always_comb begin
      mask_wr = reg_wr && reg_addr == i2c_flags_pkg::OFF_IRQ_MASK;
      mode_wr = reg_wr && reg_addr == i2c_flags_pkg::OFF_MODE_CONTROL;
      st_wr = reg_wr && reg_addr == i2c_flags_pkg::OFF_STATUS;
      mask_d = mask_wr ? reg_wdata : mask_q;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= 16'h0000;
      end else begin
         mask_q <= mask_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_tx_load;
      tx_copied && !module_in_reset && mask_q[4] && !mask_wr;
   endsequence
   sequence s_rx_load;
      rx_copied && !module_in_reset && mask_q[3] && !mask_wr && !mode_wr;
   endsequence
   property p_tx_set;
      s_tx_load |-> ##2 tx_ready_request;
   endproperty
   a_tx_set: assert property (p_tx_set) else $error("tx request missing");
   property p_rx_set;
      s_rx_load |-> ##2 rx_ready_request;
   endproperty
   a_rx_set: assert property (p_rx_set) else $error("rx request missing");
   property p_tx_clr;
      reg_wr && reg_addr == i2c_flags_pkg::OFF_TX_DATA && !tx_copied && !module_in_reset
         |-> ##2 !tx_ready_request;
   endproperty
   a_tx_clr: assert property (p_tx_clr) else $error("tx request kept");
   property p_rx_clr;
      reg_rd && reg_addr == i2c_flags_pkg::OFF_RX_DATA && !rx_copied |-> ##2 !rx_ready_request;
   endproperty
   a_rx_clr: assert property (p_rx_clr) else $error("rx request kept");
   property p_regs_clr;
      regs_start && !regs_consumed |-> ##2 !regs_ready_request;
   endproperty
   a_regs_clr: assert property (p_regs_clr) else $error("access request kept");
   property p_regs_w1c;
      st_wr && reg_wdata[2] && !regs_consumed |-> ##2 !regs_ready_request;
   endproperty
   a_regs_w1c: assert property (p_regs_w1c) else $error("access w1c failed");
   property p_hold_tx;
      (module_in_reset && mask_q[4]) [*3] |=> tx_ready_request;
   endproperty
   a_hold_tx: assert property (p_hold_tx) else $error("tx not forced");
   property p_rx_mask;
      !mask_q[3] |=> !rx_ready_request;
   endproperty
   a_rx_mask: assert property (p_rx_mask) else $error("masked rx request");
   property p_rsvd;
      $past(reg_rd) && $past(reg_addr) == i2c_flags_pkg::OFF_STATUS |-> reg_rdata[7:6] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

// ==== testbench/bus_agent.sv ====
// far-side model: bus engine event pulses
`timescale 1ns/10ps
module bus_agent (
   input wire logic clk,
   output logic [6:0] ev,
   output logic [7:0] addr_byte,
   output logic [7:0] rx_shift_reg
);
   initial begin
      ev = 7'h00;
      addr_byte = 8'h00;
      rx_shift_reg = 8'h00;
   end
   // data lines invert after the pulse so stale values never look valid
   task automatic fire(input logic [6:0] e, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      ev <= e;
      addr_byte <= a;
      rx_shift_reg <= d;
      @(posedge clk);
      ev <= 7'h00;
      addr_byte <= ~a;
      rx_shift_reg <= ~d;
   endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the status flag block
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic master_mode = 1'b0;
   logic [15:0] reg_rdata;
   logic [6:0] ev;
   logic [7:0] addr_byte, rx_shift_reg, tx_data, b;
   logic module_in_reset, tx_ready_request, rx_ready_request, regs_ready_request, irq;
   logic [15:0] st, msk, d;
   logic rst_m = 1'b1;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   i2c_status_flags i_i2c_status_flags (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .master_mode, .start_seen(ev[0]), .stop_seen(ev[1]),
      .addr_valid(ev[2]), .addr_byte, .tx_copied(ev[3]), .rx_copied(ev[4]), .rx_shift_reg,
      .regs_consumed(ev[5]), .regs_start(ev[6]), .tx_data, .module_in_reset,
      .tx_ready_request, .rx_ready_request, .regs_ready_request, .irq);
   bus_agent i_bus_agent (.clk, .ev, .addr_byte, .rx_shift_reg);
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (a == i2c_flags_pkg::OFF_MODE_CONTROL) rst_m = ~v[0];
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   function automatic logic [2:0] vec(input logic [15:0] s);
      logic [15:0] m;
      m = s & msk;
      if (m[2]) return i2c_flags_pkg::CODE_REGS_READY;
      if (m[3]) return i2c_flags_pkg::CODE_RX_READY;
      if (m[4]) return i2c_flags_pkg::CODE_TX_READY;
      if (m[5]) return 3'h6;
      if (m[8]) return i2c_flags_pkg::CODE_GENERAL_CALL;
      return i2c_flags_pkg::CODE_NONE;
   endfunction
   task automatic chk_st;
      logic [15:0] v;
      rd(i2c_flags_pkg::OFF_STATUS, v);
      chk("status", st, v);
      chk("in_reset", {15'h0, rst_m}, {15'h0, module_in_reset});
      chk("irq", {15'h0, |(st & msk)}, {15'h0, irq});
      chk("tx_req", {15'h0, st[4] & msk[4]}, {15'h0, tx_ready_request});
      chk("rx_req", {15'h0, st[3] & msk[3]}, {15'h0, rx_ready_request});
      chk("regs_req", {15'h0, st[2] & msk[2]}, {15'h0, regs_ready_request});
   endtask
   // stop flag falls only when the read returns the stop code
   task automatic vr;
      logic [15:0] v;
      logic [2:0] c;
      c = vec(st);
      rd(i2c_flags_pkg::OFF_IRQ_VECTOR, v);
      chk("vector", {13'h0, c}, v);
      if (c == 3'h6) st[5] = 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      void'($urandom(91709));
      st = 16'h0010;
      msk = 16'h0000;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      chk_st;
      rd(8'h20, d);
      chk("unmapped", 16'h0000, d);
      i_bus_agent.fire(7'h1a, 8'h00, 8'h5a);
      chk_st;
      msk = 16'h013c;
      wr(i2c_flags_pkg::OFF_IRQ_MASK, 16'hffff);
      rd(i2c_flags_pkg::OFF_IRQ_MASK, d);
      chk("mask", msk, d);
      chk_st;
      wr(i2c_flags_pkg::OFF_MODE_CONTROL, 16'h0001);
      b = 8'($urandom);
      wr(i2c_flags_pkg::OFF_TX_DATA, {8'h00, b});
      st[4] = 1'b0;
      chk_st;
      chk("tx_data", {8'h00, b}, {8'h00, tx_data});
      rd(i2c_flags_pkg::OFF_TX_DATA, d);
      chk("tx_rd", {8'h00, b}, d);
      i_bus_agent.fire(7'h08, 8'hff, 8'h00);
      st[4] = 1'b1;
      chk_st;
      wr(i2c_flags_pkg::OFF_STATUS, 16'h00d0);
      st[4] = 1'b0;
      chk_st;
      b = 8'($urandom);
      i_bus_agent.fire(7'h10, 8'hff, b);
      st[3] = 1'b1;
      chk_st;
      rd(i2c_flags_pkg::OFF_RX_DATA, d);
      chk("rx_data", {8'h00, b}, d);
      st[3] = 1'b0;
      chk_st;
      i_bus_agent.fire(7'h04, 8'h80, 8'h00);
      chk_st;
      i_bus_agent.fire(7'h04, 8'h00, 8'h00);
      st[8] = 1'b1;
      chk_st;
      vr;
      i_bus_agent.fire(7'h01, 8'hff, 8'h00);
      st[8] = 1'b0;
      chk_st;
      i_bus_agent.fire(7'h04, 8'h00, 8'h00);
      i_bus_agent.fire(7'h02, 8'hff, 8'h00);
      st[5] = 1'b1;
      chk_st;
      vr;
      chk_st;
      i_bus_agent.fire(7'h02, 8'hff, 8'h00);
      st[5] = 1'b1;
      wr(i2c_flags_pkg::OFF_STATUS, 16'h0000);
      chk_st;
      wr(i2c_flags_pkg::OFF_STATUS, 16'h0020);
      st[5] = 1'b0;
      chk_st;
      i_bus_agent.fire(7'h20, 8'hff, 8'h00);
      chk_st;
      @(posedge clk);
      master_mode <= 1'b1;
      i_bus_agent.fire(7'h20, 8'hff, 8'h00);
      st[2] = 1'b1;
      chk_st;
      i_bus_agent.fire(7'h40, 8'hff, 8'h00);
      st[2] = 1'b0;
      chk_st;
      i_bus_agent.fire(7'h20, 8'hff, 8'h00);
      wr(i2c_flags_pkg::OFF_STATUS, 16'h0004);
      chk_st;
      msk = 16'h0000;
      wr(i2c_flags_pkg::OFF_IRQ_MASK, 16'h0000);
      i_bus_agent.fire(7'h18, 8'hff, 8'h3c);
      st[4:3] = 2'h3;
      chk_st;
      msk = 16'h013c;
      wr(i2c_flags_pkg::OFF_IRQ_MASK, 16'h013c);
      wr(i2c_flags_pkg::OFF_MODE_CONTROL, 16'h0000);
      st = 16'h0010;
      chk_st;
      wr(i2c_flags_pkg::OFF_MODE_CONTROL, 16'h0001);
      // random event bursts, vector reads and clears
      repeat (40) begin
         d = 16'($urandom);
         i_bus_agent.fire({1'b0, d[3:1], 1'b0, d[0], 1'b0}, 8'hff, 8'($urandom));
         st[5:2] = st[5:2] | {d[0], d[1], d[2], d[3]};
         if (d[4]) vr;
         d = 16'($urandom);
         wr(i2c_flags_pkg::OFF_STATUS, d);
         st = st & ~(d & 16'h003c);
         chk_st;
      end
      end_of_test;
   end
endmodule
bind i2c_status_flags i2c_flags_chk i_i2c_flags_chk (.clk, .arst_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .tx_copied, .rx_copied, .regs_consumed, .regs_start,
   .module_in_reset, .tx_ready_request, .rx_ready_request, .regs_ready_request);
